// [sdrb_top.sv]
// Read-only diagnostic holding register bank behind the Modbus access port
//
// Contract
// [RULE_01] Rated speed, 32 bits over two registers at 2D28h, read by 03h.
// [RULE_02] Maximum speed, 32 bits over two registers at 2D29h, read by 03h.
// [RULE_03] Latest abort code readable at 2A60h; zero means no error.
// [RULE_04] Unsupported 06010000h, read write-only 06010001h, write read-only 06010002h.
// [RULE_05] No object 06020000h, no sub-index 06090011h, length mismatch 06070010h.
// [RULE_06] Write range codes: exceeded 06090030h, too high 06090031h, too low 06090032h.
// [RULE_07] Refused by local control 08000021h, by device state 08000022h.
// [RULE_08] Log at 2A64h: index in upper half, zero-extended sub-index lower.
// [RULE_09] Register 2A65h counts addresses reached in the last access.
// [RULE_10] Parity, overrun and framing errors each add one to 2A68h.
// [RULE_11] Frame length errors and CRC errors add to the same total.
// [RULE_12] Alarm history clear resets the communication error total.
// [RULE_13] Profile word, 32 bits over two registers at 1000h.
// [RULE_14] Writes to the bank are refused and log the read-only code.
`timescale 1ns/1ns
module sdrb_top #(
  // Profile word content; value is arbitrary
  parameter logic [31:0] PROFILE_WORD = 32'h0001_0001
) (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_reset,

  // Access request from the frame layer
  input  wire logic        i_req_valid,
  output logic             o_req_ready,
  input  wire logic [7:0]  i_req_func,
  input  wire logic [15:0] i_req_index,
  input  wire logic [7:0]  i_req_subidx,
  input  wire logic [7:0]  i_req_count,

  // Read data words, first word first
  output logic             o_rsp_valid,
  input  wire logic        i_rsp_ready,
  output logic [15:0]      o_rsp_data,
  output logic             o_rsp_last,

  // End of access
  output logic             o_done,
  output logic             o_done_ok,
  output logic [31:0]      o_done_code,

  // Outcome of accesses served elsewhere in the device
  input  wire logic        i_ext_valid,
  input  wire logic [15:0] i_ext_index,
  input  wire logic [7:0]  i_ext_subidx,
  input  wire logic [15:0] i_ext_reached,
  input  wire logic [3:0]  i_ext_cause,

  // Motor data
  input  wire logic [31:0] i_rated_speed,
  input  wire logic [31:0] i_max_speed,

  // Serial receiver error pulses
  input  wire logic        i_parity_err,
  input  wire logic        i_overrun_err,
  input  wire logic        i_framing_err,
  input  wire logic        i_length_err,
  input  wire logic        i_crc_err,

  // Alarm history clear action
  input  wire logic        i_alarm_hist_clear
);

  typedef struct packed {
    sdrb_pkg::sdrb_state_t state;
    sdrb_pkg::sdrb_obj_t   obj;
    logic [7:0]            func;
    logic [15:0]           index;
    logic [7:0]            subidx;
    logic [7:0]            count;
    logic [7:0]            sent;
    logic [31:0]           shadow;
    logic [31:0]           abort_code;
    logic [31:0]           idx_log;
    logic [15:0]           cnt_log;
    logic                  done;
    logic                  done_ok;
    logic [31:0]           done_code;
  } sdrb_bank_t;

  sdrb_bank_t s;
  sdrb_bank_t next_s;

  sdrb_cnt_if cnt ();

  // Address decode of the holding register map
  function automatic sdrb_pkg::sdrb_obj_t obj_lookup(input logic [15:0] addr);
    case (addr)
      sdrb_pkg::ADDR_PROFILE: obj_lookup = sdrb_pkg::OBJ_PROFILE;
      sdrb_pkg::ADDR_ABORT:   obj_lookup = sdrb_pkg::OBJ_ABORT;
      sdrb_pkg::ADDR_IDX_LOG: obj_lookup = sdrb_pkg::OBJ_IDX_LOG;
      sdrb_pkg::ADDR_CNT_LOG: obj_lookup = sdrb_pkg::OBJ_CNT_LOG;
      sdrb_pkg::ADDR_ERR_TOT: obj_lookup = sdrb_pkg::OBJ_ERR_TOT;
      sdrb_pkg::ADDR_RATED:   obj_lookup = sdrb_pkg::OBJ_RATED;
      sdrb_pkg::ADDR_MAXSPD:  obj_lookup = sdrb_pkg::OBJ_MAXSPD;
      default:                obj_lookup = sdrb_pkg::OBJ_NONE;
    endcase
  endfunction

  // Register words that make up each object
  function automatic logic [7:0] obj_words(input sdrb_pkg::sdrb_obj_t obj);
    case (obj)
      sdrb_pkg::OBJ_PROFILE,
      sdrb_pkg::OBJ_ABORT,
      sdrb_pkg::OBJ_IDX_LOG,
      sdrb_pkg::OBJ_RATED,
      sdrb_pkg::OBJ_MAXSPD:  obj_words = sdrb_pkg::WORDS_LONG;
      sdrb_pkg::OBJ_CNT_LOG,
      sdrb_pkg::OBJ_ERR_TOT: obj_words = sdrb_pkg::WORDS_SHORT;
      default:               obj_words = sdrb_pkg::WORDS_NONE;
    endcase
  endfunction

  // Fault cause to abort code
  function automatic logic [31:0] cause_code(input logic [3:0] cause);
    case (sdrb_pkg::sdrb_cause_t'(cause))
      sdrb_pkg::CAUSE_UNSUP:    cause_code = sdrb_pkg::CODE_UNSUP;    // see [RULE_04]
      sdrb_pkg::CAUSE_RD_WO:    cause_code = sdrb_pkg::CODE_RD_WO;    // see [RULE_04]
      sdrb_pkg::CAUSE_WR_RO:    cause_code = sdrb_pkg::CODE_WR_RO;    // see [RULE_04]
      sdrb_pkg::CAUSE_NO_OBJ:   cause_code = sdrb_pkg::CODE_NO_OBJ;   // see [RULE_05]
      sdrb_pkg::CAUSE_LENGTH:   cause_code = sdrb_pkg::CODE_LENGTH;   // see [RULE_05]
      sdrb_pkg::CAUSE_NO_SUB:   cause_code = sdrb_pkg::CODE_NO_SUB;   // see [RULE_05]
      sdrb_pkg::CAUSE_RANGE:    cause_code = sdrb_pkg::CODE_RANGE;    // see [RULE_06]
      sdrb_pkg::CAUSE_HIGH:     cause_code = sdrb_pkg::CODE_HIGH;     // see [RULE_06]
      sdrb_pkg::CAUSE_LOW:      cause_code = sdrb_pkg::CODE_LOW;      // see [RULE_06]
      sdrb_pkg::CAUSE_LOCAL:    cause_code = sdrb_pkg::CODE_LOCAL;    // see [RULE_07]
      sdrb_pkg::CAUSE_DEVSTATE: cause_code = sdrb_pkg::CODE_DEVSTATE; // see [RULE_07]
      default:                  cause_code = sdrb_pkg::CODE_NONE;
    endcase
  endfunction

  // Checks of one bank access, most basic fault first
  function automatic logic [31:0] check_access(
    input logic [7:0]          func,
    input sdrb_pkg::sdrb_obj_t obj,
    input logic [7:0]          subidx,
    input logic [7:0]          count
  );
    if (func != sdrb_pkg::FN_READ && func != sdrb_pkg::FN_WRITE) begin
      check_access = sdrb_pkg::CODE_UNSUP;                  // see [RULE_04]
    end else if (obj == sdrb_pkg::OBJ_NONE) begin
      check_access = sdrb_pkg::CODE_NO_OBJ;                 // see [RULE_05]
    end else if (func == sdrb_pkg::FN_WRITE) begin
      check_access = sdrb_pkg::CODE_WR_RO;                  // see [RULE_14]
    end else if (subidx != sdrb_pkg::SUBIDX_ONLY) begin
      check_access = sdrb_pkg::CODE_NO_SUB;                 // see [RULE_05]
    end else if (count != obj_words(obj)) begin
      check_access = sdrb_pkg::CODE_LENGTH;                 // see [RULE_05]
    end else begin
      check_access = sdrb_pkg::CODE_NONE;
    end
  endfunction

  // Snapshot of a readable value, first word in the upper half
  function automatic logic [31:0] obj_value(
    input sdrb_pkg::sdrb_obj_t obj,
    input logic [31:0]         abort_code,
    input logic [31:0]         idx_log,
    input logic [15:0]         cnt_log,
    input logic [15:0]         err_total,
    input logic [31:0]         rated,
    input logic [31:0]         maxspd
  );
    case (obj)
      sdrb_pkg::OBJ_PROFILE: obj_value = PROFILE_WORD;      // see [RULE_13]
      sdrb_pkg::OBJ_ABORT:   obj_value = abort_code;        // see [RULE_03]
      sdrb_pkg::OBJ_IDX_LOG: obj_value = idx_log;           // see [RULE_08]
      sdrb_pkg::OBJ_CNT_LOG: obj_value = {cnt_log, sdrb_pkg::RST_WORD16};
      sdrb_pkg::OBJ_ERR_TOT: obj_value = {err_total, sdrb_pkg::RST_WORD16};
      sdrb_pkg::OBJ_RATED:   obj_value = rated;             // see [RULE_01]
      sdrb_pkg::OBJ_MAXSPD:  obj_value = maxspd;            // see [RULE_02]
      default:               obj_value = sdrb_pkg::RST_WORD32;
    endcase
  endfunction

  // Serial error events to the counter; same-clock pulses, no sync
  assign cnt.err_evt = {i_crc_err, i_length_err, i_framing_err,
                        i_overrun_err, i_parity_err};  // see [RULE_10] see [RULE_11]
  assign cnt.clear   = i_alarm_hist_clear;              // see [RULE_12]

  sdrb_err_counter u_err_counter (
    .i_mclk  (i_mclk),
    .i_reset (i_reset),
    .cnt     (cnt.counter)
  );

  // Sequencer and log update
  always_comb begin
    logic [31:0] code;
    logic        own_log;
    logic        last_word;
    code      = sdrb_pkg::CODE_NONE;
    own_log   = 1'b0;
    last_word = (s.sent + 8'h01) == s.count;
    next_s      = s;
    next_s.done = 1'b0;

    case (s.state)
      sdrb_pkg::ST_IDLE: begin
        if (i_req_valid) begin
          next_s.func   = i_req_func;
          next_s.index  = i_req_index;
          next_s.subidx = i_req_subidx;
          next_s.count  = i_req_count;
          next_s.obj    = obj_lookup(i_req_index);
          next_s.sent   = sdrb_pkg::RST_BYTE;
          next_s.state  = sdrb_pkg::ST_CHECK;
        end
      end

      sdrb_pkg::ST_CHECK: begin
        code = check_access(s.func, s.obj, s.subidx, s.count);
        if (code == sdrb_pkg::CODE_NONE) begin
          // Value frozen here so both halves come from one instant
          next_s.shadow = obj_value(s.obj, s.abort_code, s.idx_log,
                                    s.cnt_log, cnt.total,
                                    i_rated_speed, i_max_speed);
          next_s.state  = sdrb_pkg::ST_SEND;
        end else begin
          // Refused accesses still set the abort code and both logs
          own_log      = 1'b1;                               // see [RULE_14]
          next_s.state = sdrb_pkg::ST_DONE;
        end
      end

      sdrb_pkg::ST_SEND: begin
        if (i_rsp_ready) begin
          next_s.sent   = s.sent + 8'h01;
          next_s.shadow = s.shadow << sdrb_pkg::HALF_BITS;
          if (last_word) begin
            own_log      = 1'b1;
            next_s.state = sdrb_pkg::ST_DONE;
          end
        end
      end

      sdrb_pkg::ST_DONE: begin
        next_s.state = sdrb_pkg::ST_IDLE;
      end

      default: begin
        next_s.state = sdrb_pkg::ST_IDLE;
      end
    endcase

    // Own access closes: abort code, both logs and the done pulse
    if (own_log) begin
      next_s.abort_code = code;                               // see [RULE_03]
      next_s.idx_log    = {s.index, sdrb_pkg::RST_BYTE, s.subidx}; // see [RULE_08]
      next_s.cnt_log    = {sdrb_pkg::RST_BYTE, next_s.sent};  // see [RULE_09]
      next_s.done       = 1'b1;
      next_s.done_ok    = (code == sdrb_pkg::CODE_NONE);
      next_s.done_code  = code;
    end else if (i_ext_valid) begin
      // Accesses served elsewhere share the same log
      next_s.abort_code = cause_code(i_ext_cause);            // see [RULE_03]
      next_s.idx_log    = {i_ext_index, sdrb_pkg::RST_BYTE, i_ext_subidx}; // see [RULE_08]
      next_s.cnt_log    = i_ext_reached;                      // see [RULE_09]
    end
  end

  // State register; control state and logs start cleared
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      s.state      <= sdrb_pkg::ST_IDLE;
      s.obj        <= sdrb_pkg::OBJ_NONE;
      s.func       <= sdrb_pkg::RST_BYTE;
      s.index      <= sdrb_pkg::RST_WORD16;
      s.subidx     <= sdrb_pkg::RST_BYTE;
      s.count      <= sdrb_pkg::RST_BYTE;
      s.sent       <= sdrb_pkg::RST_BYTE;
      s.shadow     <= sdrb_pkg::RST_WORD32;
      s.abort_code <= sdrb_pkg::CODE_NONE;
      s.idx_log    <= sdrb_pkg::RST_WORD32;
      s.cnt_log    <= sdrb_pkg::RST_WORD16;
      s.done       <= 1'b0;
      s.done_ok    <= 1'b0;
      s.done_code  <= sdrb_pkg::CODE_NONE;
    end else begin
      s <= next_s;
    end
  end

  // Handshakes straight from the state, data from flip-flops
  assign o_req_ready = (s.state == sdrb_pkg::ST_IDLE);
  assign o_rsp_valid = (s.state == sdrb_pkg::ST_SEND);
  assign o_rsp_last  = o_rsp_valid && ((s.sent + 8'h01) == s.count);
  assign o_rsp_data  = s.shadow[31:16];                     // see [RULE_01] see [RULE_02]
  assign o_done      = s.done;
  assign o_done_ok   = s.done_ok;
  assign o_done_code = s.done_code;

endmodule

// [sdrb_pkg.sv]
// Constants, types and map of the serial diagnostic register bank
package sdrb_pkg;

  // Modbus function codes handled by the bank
  localparam logic [7:0]  FN_READ       = 8'h03;
  localparam logic [7:0]  FN_WRITE      = 8'h10;

  // Holding register addresses
  localparam logic [15:0] ADDR_PROFILE  = 16'h1000;
  localparam logic [15:0] ADDR_ABORT    = 16'h2A60;
  localparam logic [15:0] ADDR_IDX_LOG  = 16'h2A64;
  localparam logic [15:0] ADDR_CNT_LOG  = 16'h2A65;
  localparam logic [15:0] ADDR_ERR_TOT  = 16'h2A68;
  localparam logic [15:0] ADDR_RATED    = 16'h2D28;
  localparam logic [15:0] ADDR_MAXSPD   = 16'h2D29;

  // Register words per object
  localparam logic [7:0]  WORDS_LONG    = 8'h02;
  localparam logic [7:0]  WORDS_SHORT   = 8'h01;
  localparam logic [7:0]  WORDS_NONE    = 8'h00;

  // Only sub-index of every object in this bank
  localparam logic [7:0]  SUBIDX_ONLY   = 8'h00;

  // Reset values
  localparam logic [31:0] RST_WORD32    = 32'h0000_0000;
  localparam logic [15:0] RST_WORD16    = 16'h0000;
  localparam logic [7:0]  RST_BYTE      = 8'h00;

  // Shift between the two halves of a long value
  localparam int          HALF_BITS     = 16;

  // Number of serial error sources feeding the total
  localparam int          ERR_SOURCES   = 5;

  // Object access abort codes
  localparam logic [31:0] CODE_NONE     = 32'h0000_0000;
  localparam logic [31:0] CODE_UNSUP    = 32'h0601_0000;
  localparam logic [31:0] CODE_RD_WO    = 32'h0601_0001;
  localparam logic [31:0] CODE_WR_RO    = 32'h0601_0002;
  localparam logic [31:0] CODE_NO_OBJ   = 32'h0602_0000;
  localparam logic [31:0] CODE_LENGTH   = 32'h0607_0010;
  localparam logic [31:0] CODE_NO_SUB   = 32'h0609_0011;
  localparam logic [31:0] CODE_RANGE    = 32'h0609_0030;
  localparam logic [31:0] CODE_HIGH     = 32'h0609_0031;
  localparam logic [31:0] CODE_LOW      = 32'h0609_0032;
  localparam logic [31:0] CODE_LOCAL    = 32'h0800_0021;
  localparam logic [31:0] CODE_DEVSTATE = 32'h0800_0022;

  // Fault causes reported by the rest of the device
  typedef enum logic [3:0] {
    CAUSE_NONE, CAUSE_UNSUP, CAUSE_RD_WO, CAUSE_WR_RO,
    CAUSE_NO_OBJ, CAUSE_LENGTH, CAUSE_NO_SUB, CAUSE_RANGE,
    CAUSE_HIGH, CAUSE_LOW, CAUSE_LOCAL, CAUSE_DEVSTATE
  } sdrb_cause_t;

  // Objects held by the bank
  typedef enum logic [2:0] {
    OBJ_NONE, OBJ_PROFILE, OBJ_ABORT, OBJ_IDX_LOG,
    OBJ_CNT_LOG, OBJ_ERR_TOT, OBJ_RATED, OBJ_MAXSPD
  } sdrb_obj_t;

  // Access sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_CHECK = 4'b0010,
    ST_SEND  = 4'b0100,
    ST_DONE  = 4'b1000
  } sdrb_state_t;

endpackage

// [sdrb_cnt_if.sv]
// Link between the bank and its communication error counter
`timescale 1ns/1ns
interface sdrb_cnt_if;
  logic [sdrb_pkg::ERR_SOURCES-1:0] err_evt;
  logic                             clear;
  logic [15:0]                      total;

  modport counter (input err_evt, input clear, output total);
  modport owner   (output err_evt, output clear, input total);
endinterface

// [sdrb_err_counter.sv]
// Communication error total, one count per error event
`timescale 1ns/1ns
module sdrb_err_counter (
  // Clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  // Events, clear and total
  sdrb_cnt_if.counter      cnt
);

  typedef struct packed {
    logic [15:0] total;
  } sdrb_cnt_state_t;

  sdrb_cnt_state_t s;
  sdrb_cnt_state_t next_s;

  // Several sources may fire together, so each adds its own count
  always_comb begin
    logic [16:0] sum;
    logic [15:0] inc;
    inc = 16'($countones(cnt.err_evt));
    sum = {1'b0, s.total} + {1'b0, inc};
    next_s = s;
    if (cnt.clear) begin
      next_s.total = inc;                // see [RULE_12]
    end else if (sum[16]) begin
      next_s.total = 16'hFFFF;           // Saturate, never wrap to a clean value
    end else begin
      next_s.total = sum[15:0];          // see [RULE_10] see [RULE_11]
    end
  end

  // State register
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      s.total <= sdrb_pkg::RST_WORD16;
    end else begin
      s <= next_s;
    end
  end

  assign cnt.total = s.total;

endmodule

// [sdrb_top_asserts.sv]
// Port-level assertions for the diagnostic register bank
`timescale 1ns/1ns
module sdrb_top_asserts (
  // Clock and reset
  input wire logic        i_mclk,
  input wire logic        i_reset,
  // Access port
  input wire logic        i_req_valid,
  input wire logic        o_req_ready,
  input wire logic [7:0]  i_req_func,
  input wire logic [15:0] i_req_index,
  input wire logic [7:0]  i_req_subidx,
  input wire logic [7:0]  i_req_count,
  input wire logic        o_rsp_valid,
  input wire logic        i_rsp_ready,
  input wire logic [15:0] o_rsp_data,
  input wire logic        o_rsp_last,
  input wire logic        o_done,
  input wire logic        o_done_ok,
  input wire logic [31:0] o_done_code,
  // Motor data
  input wire logic [31:0] i_rated_speed
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // Request taken at this edge
  logic tk;
  assign tk = i_req_valid && o_req_ready;

  property p_done_pulse; o_done |=> !o_done && o_req_ready; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done pulse too long");
  property p_ok_zero; o_done && o_done_ok |-> o_done_code == sdrb_pkg::CODE_NONE; endproperty
  a_ok_zero: assert property (p_ok_zero) else $error("ok access with nonzero code");
  property p_err_code; o_done && !o_done_ok |-> o_done_code != sdrb_pkg::CODE_NONE; endproperty
  a_err_code: assert property (p_err_code) else $error("failed access with zero code");
  property p_unsup;
    tk && i_req_func != sdrb_pkg::FN_READ && i_req_func != sdrb_pkg::FN_WRITE
      |-> ##2 o_done && o_done_code == sdrb_pkg::CODE_UNSUP;
  endproperty
  a_unsup: assert property (p_unsup) else $error("unsupported function code wrong");
  property p_write_ro;
    tk && i_req_func == sdrb_pkg::FN_WRITE && i_req_index == sdrb_pkg::ADDR_RATED
      |-> ##2 o_done && !o_done_ok && o_done_code == sdrb_pkg::CODE_WR_RO;
  endproperty
  a_write_ro: assert property (p_write_ro) else $error("write not refused");
  property p_no_sub;
    tk && i_req_func == sdrb_pkg::FN_READ && i_req_index == sdrb_pkg::ADDR_ABORT
      && i_req_subidx != sdrb_pkg::SUBIDX_ONLY |-> ##2 o_done && o_done_code == sdrb_pkg::CODE_NO_SUB;
  endproperty
  a_no_sub: assert property (p_no_sub) else $error("bad sub-index code wrong");
  property p_rated_hi;
    tk && i_req_func == sdrb_pkg::FN_READ && i_req_index == sdrb_pkg::ADDR_RATED && i_req_subidx == 8'h00
      && i_req_count == sdrb_pkg::WORDS_LONG |-> ##2 o_rsp_valid && !o_rsp_last && o_rsp_data == i_rated_speed[31:16];
  endproperty
  a_rated_hi: assert property (p_rated_hi) else $error("rated speed upper word wrong");
  property p_rsp_hold; o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp_data); endproperty
  a_rsp_hold: assert property (p_rsp_hold) else $error("read word dropped while stalled");
  // Last word taken closes an ok access on the next cycle
  property p_last_done; o_rsp_valid && o_rsp_last && i_rsp_ready |=> o_done && o_done_ok; endproperty
  a_last_done: assert property (p_last_done) else $error("last word not followed by done");
  property p_busy; tk |=> !o_req_ready ##1 !o_req_ready; endproperty
  a_busy: assert property (p_busy) else $error("second request accepted too early");
endmodule

bind sdrb_top sdrb_top_asserts chk_u (.i_mclk(i_mclk), .i_reset(i_reset), .i_req_valid(i_req_valid),
  .o_req_ready(o_req_ready), .i_req_func(i_req_func), .i_req_index(i_req_index), .i_req_subidx(i_req_subidx),
  .i_req_count(i_req_count), .o_rsp_valid(o_rsp_valid), .i_rsp_ready(i_rsp_ready), .o_rsp_data(o_rsp_data),
  .o_rsp_last(o_rsp_last), .o_done(o_done), .o_done_ok(o_done_ok), .o_done_code(o_done_code),
  .i_rated_speed(i_rated_speed));

// [sdrb_master_model.sv]
// Bus master model issuing holding register accesses
`timescale 1ns/1ns
module sdrb_master_model (
  // Clock
  input  wire logic        i_mclk,
  // Request
  output logic             o_req_valid,
  input  wire logic        i_req_ready,
  output logic [7:0]       o_req_func,
  output logic [15:0]      o_req_index,
  output logic [7:0]       o_req_subidx,
  output logic [7:0]       o_req_count,
  // Response
  input  wire logic        i_rsp_valid,
  output logic             o_rsp_ready,
  input  wire logic [15:0] i_rsp_data,
  input  wire logic        i_done,
  input  wire logic        i_done_ok,
  input  wire logic [31:0] i_done_code
);
  initial begin
    o_req_valid = 1'b0;
    o_req_func = 8'h00;
    o_req_index = 16'h0000;
    o_req_subidx = 8'h00;
    o_req_count = 8'h00;
    o_rsp_ready = 1'b0;
  end

  // One access; words arrive upper first, stall halves the take rate
  task automatic access(input logic [7:0] f, input logic [15:0] a, input logic [7:0] s, input logic [7:0] n,
                        input logic stall, output logic [31:0] rd, output logic ok, output logic [31:0] code);
    rd = 32'h0;
    ok = 1'b0;
    code = 32'hFFFF_FFFF;
    @(posedge i_mclk);
    o_req_valid <= 1'b1;
    o_req_func <= f;
    o_req_index <= a;
    o_req_subidx <= s;
    o_req_count <= n;
    // Hold until ready is seen, then let the edge take it
    do @(negedge i_mclk); while (!i_req_ready);
    @(posedge i_mclk);
    o_req_valid <= 1'b0;
    o_req_index <= ~a; // Released fields show no stale address
    repeat (40) begin
      @(negedge i_mclk);
      if (i_done) begin
        ok = i_done_ok;
        code = i_done_code;
        break;
      end
      if (i_rsp_valid && o_rsp_ready)
        rd = {rd[15:0], i_rsp_data};
      @(posedge i_mclk);
      o_rsp_ready <= stall ? !o_rsp_ready : 1'b1;
    end
  endtask
endmodule

// [sdrb_top_tb_top.sv]
// Self-checking testbench for the diagnostic register bank
`timescale 1ns/1ns
module sdrb_top_tb_top;
  localparam logic [31:0] PROFILE = 32'h00A5_005A; // Arbitrary value
  localparam logic [31:0] RATED = 32'h0BB8_1234;
  localparam logic [31:0] MAXSPD = 32'h1770_ABCD;
  logic        i_mclk = 1'b0;
  logic        i_reset = 1'b1;
  logic        req_valid, req_ready, rsp_valid, rsp_ready, rsp_last, done, done_ok;
  logic [7:0]  req_func, req_subidx, req_count;
  logic [15:0] req_index, rsp_data;
  logic [31:0] done_code;
  logic        ext_valid = 1'b0;
  logic [3:0]  ext_cause = 4'h0;
  logic [4:0]  err_v = 5'h00;
  logic        hist_clr = 1'b0;
  logic [31:0] codes [12];
  int          n_fail = 0;
  int          compares = 0;

  // Clock
  always #50 i_mclk = ~i_mclk;

  sdrb_top #(.PROFILE_WORD(PROFILE)) dut_u (.i_mclk(i_mclk), .i_reset(i_reset), .i_req_valid(req_valid),
    .o_req_ready(req_ready), .i_req_func(req_func), .i_req_index(req_index), .i_req_subidx(req_subidx),
    .i_req_count(req_count), .o_rsp_valid(rsp_valid), .i_rsp_ready(rsp_ready), .o_rsp_data(rsp_data),
    .o_rsp_last(rsp_last), .o_done(done), .o_done_ok(done_ok), .o_done_code(done_code),
    .i_ext_valid(ext_valid), .i_ext_index(16'h2801), .i_ext_subidx(8'h07), .i_ext_reached(16'h0006),
    .i_ext_cause(ext_cause), .i_rated_speed(RATED), .i_max_speed(MAXSPD), .i_parity_err(err_v[0]),
    .i_overrun_err(err_v[1]), .i_framing_err(err_v[2]), .i_length_err(err_v[3]), .i_crc_err(err_v[4]),
    .i_alarm_hist_clear(hist_clr));

  sdrb_master_model mst_u (.i_mclk(i_mclk), .o_req_valid(req_valid), .i_req_ready(req_ready),
    .o_req_func(req_func), .o_req_index(req_index), .o_req_subidx(req_subidx), .o_req_count(req_count),
    .i_rsp_valid(rsp_valid), .o_rsp_ready(rsp_ready), .i_rsp_data(rsp_data), .i_done(done),
    .i_done_ok(done_ok), .i_done_code(done_code));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Any access, judged on outcome, code and returned words
  task automatic acc(input logic [7:0] f, input logic [15:0] a, input logic [7:0] s, input logic [7:0] n,
                     input logic stall, input logic [31:0] exp_code, input logic [31:0] exp_val);
    logic [31:0] v, c;
    logic ok;
    mst_u.access(f, a, s, n, stall, v, ok, c);
    chk({31'h0, ok}, {31'h0, exp_code == 32'h0});
    chk(c, exp_code);
    chk(v, exp_val);
  endtask

  // Event pulses on the error inputs and the history clear
  task automatic pulse(input logic [4:0] v, input logic clr);
    @(posedge i_mclk);
    err_v <= v;
    hist_clr <= clr;
    @(posedge i_mclk);
    err_v <= 5'h00;
    hist_clr <= 1'b0;
  endtask

  task automatic t_after_reset();
    acc(8'h03, 16'h2A60, 8'h00, 8'h02, 1'b0, 32'h0, 32'h0);
    acc(8'h03, 16'h2A64, 8'h00, 8'h02, 1'b0, 32'h0, 32'h2A60_0000);
    acc(8'h03, 16'h2A65, 8'h00, 8'h01, 1'b0, 32'h0, 32'h2);
    acc(8'h03, 16'h1000, 8'h00, 8'h02, 1'b1, 32'h0, PROFILE);
  endtask

  task automatic t_speeds();
    acc(8'h03, 16'h2D28, 8'h00, 8'h02, 1'b1, 32'h0, RATED);
    acc(8'h03, 16'h2D29, 8'h00, 8'h02, 1'b0, 32'h0, MAXSPD);
  endtask

  task automatic t_refusals();
    acc(8'h06, 16'h2D28, 8'h00, 8'h02, 1'b0, 32'h0601_0000, 32'h0);
    acc(8'h03, 16'h2A61, 8'h00, 8'h02, 1'b0, 32'h0602_0000, 32'h0);
    acc(8'h10, 16'h2D28, 8'h00, 8'h02, 1'b0, 32'h0601_0002, 32'h0);
    acc(8'h03, 16'h2A60, 8'h00, 8'h02, 1'b0, 32'h0, 32'h0601_0002);
    acc(8'h03, 16'h2A60, 8'h01, 8'h02, 1'b0, 32'h0609_0011, 32'h0);
    acc(8'h03, 16'h2A65, 8'h00, 8'h01, 1'b0, 32'h0, 32'h0);
    acc(8'h03, 16'h2D28, 8'h00, 8'h01, 1'b0, 32'h0607_0010, 32'h0);
  endtask

  // Outcomes from elsewhere in the device land in the same logs
  task automatic t_ext_codes();
    for (int c = 0; c < 14; c++) begin
      @(posedge i_mclk);
      ext_valid <= 1'b1;
      ext_cause <= (c < 12) ? c[3:0] : 4'h0;
      @(posedge i_mclk);
      ext_valid <= 1'b0;
      if (c < 12)
        acc(8'h03, 16'h2A60, 8'h00, 8'h02, 1'b0, 32'h0, codes[c]);
      else if (c == 12)
        acc(8'h03, 16'h2A64, 8'h00, 8'h02, 1'b0, 32'h0, 32'h2801_0007);
      else
        acc(8'h03, 16'h2A65, 8'h00, 8'h01, 1'b0, 32'h0, 32'h6);
    end
  endtask

  task automatic t_err_total();
    for (int i = 0; i < 5; i++)
      pulse(5'h01 << i, 1'b0);
    pulse(5'h1F, 1'b0);
    acc(8'h03, 16'h2A68, 8'h00, 8'h01, 1'b0, 32'h0, 32'hA);
    pulse(5'h01, 1'b1);
    acc(8'h03, 16'h2A68, 8'h00, 8'h01, 1'b0, 32'h0, 32'h1);
  endtask

  task automatic report_and_stop();
    $display("Compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    codes = '{sdrb_pkg::CODE_NONE, sdrb_pkg::CODE_UNSUP, sdrb_pkg::CODE_RD_WO, sdrb_pkg::CODE_WR_RO,
              sdrb_pkg::CODE_NO_OBJ, sdrb_pkg::CODE_LENGTH, sdrb_pkg::CODE_NO_SUB, sdrb_pkg::CODE_RANGE,
              sdrb_pkg::CODE_HIGH, sdrb_pkg::CODE_LOW, sdrb_pkg::CODE_LOCAL, sdrb_pkg::CODE_DEVSTATE};
    repeat (12) @(posedge i_mclk);
    i_reset <= 1'b0;
    t_after_reset();
    t_refusals();
    t_speeds();
    t_ext_codes();
    t_err_total();
    report_and_stop();
  end

  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #2000000;
    n_fail++;
    report_and_stop();
  end
endmodule
